// *** common/hub_strap_pkg.sv ***
// constants for the hub strap, port power and green led pin block
// assumes a 32-bit axi4-lite register port with 4-bit byte addresses
package hub_strap_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PORTS = 4;

  // register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PORT = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;

  // control register fields and reset value
  localparam int unsigned CTRL_ATTACH_POS = 0;
  localparam int unsigned CTRL_EXT_POS = 1;
  localparam int unsigned CTRL_LEDSUP_POS = 2;
  localparam int unsigned CTRL_W = 3;
  localparam logic [2:0] CTRL_RESET = 3'h1;

  // port register fields
  localparam int unsigned PORT_PWR_LSB = 0;
  localparam int unsigned PORT_LED_LSB = 8;
  localparam logic [3:0] PORT_PWR_RESET = 4'h0;
  localparam logic [3:0] PORT_LED_RESET = 4'h0;

  // status register fields
  localparam int unsigned STAT_VBUS_POS = 0;
  localparam int unsigned STAT_ATTACH_POS = 1;
  localparam int unsigned STAT_POL_POS = 2;
  localparam int unsigned STAT_DONE_POS = 3;
  localparam int unsigned STAT_DIS_LSB = 4;
  localparam int unsigned STAT_FIX_LSB = 8;
  localparam int unsigned STAT_DCODE_LSB = 12;
  localparam int unsigned STAT_FCODE_LSB = 14;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // strap loader: waits for reset release, then holds the straps
  typedef enum logic [1:0]
  {
    LD_WAIT = 2'h1,
    LD_DONE = 2'h2
  } loader_state_t;
endpackage

// *** design/bit_sync.sv ***
// two-stage synchroniser for a group of independent pin levels
// assumes each bit is a slow level; no reset so the pins are tracked during reset
`timescale 1ns/100ps
module bit_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb
  begin
    meta_nxt = pin_i;
    sync_nxt = meta_r;
  end

  // the first stage is read by the second stage only
  always_ff @(posedge clk_i)
  begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end

  assign sync_o = sync_r;
endmodule

// *** design/strap_ladder.sv ***
// decodes a two-bit strap code into a three-step ladder mask
// bit i of the mask is set when the code is at least i+1
`timescale 1ns/100ps
module strap_ladder (
  input wire logic [1:0] code_i,
  output logic [2:0] mask_o
);
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_step
      assign mask_o[gi] = (code_i >= 2'(gi + 1));
    end
  endgenerate
endmodule

// *** design/hub_strap_top.sv ***
// strap sampling, port power polarity and shared green led pins of a 4-port hub
// assumes an axi4-lite master on clk_i and pins from outside the clock domain
// Operation
// RULE1 - attach pull-up is enabled only while the upstream power detect pin is high.
// RULE2 - each port power enable output switches its port with the strapped active level.
// RULE3 - with led support enabled by external configuration all green leds are active low.
// RULE4 - green led pins of ports 4 and 3 are sampled at reset release as the disable strap.
// RULE5 - disable strap 00 none, 01 port 4, 10 ports 4 and 3, 11 ports 4, 3 and 2.
// RULE6 - port 4 green led is active low if the disable strap upper bit was 1, port 3 by lower.
// RULE7 - green led pins of ports 2 and 1 are sampled at reset release as the fixed device strap.
// RULE8 - fixed strap 00 none, 01 port 1, 10 ports 1 and 2, 11 ports 1, 2 and 3.
// RULE9 - port 2 green led is active low if the fixed strap upper bit was 1, port 1 by lower.
// RULE10 - during reset the polarity pin sets the power outputs inactive combinationally.
// RULE11 - the polarity pin is latched at reset release, 1 active high and 0 active low.
// RULE12 - latched straps stay constant until next reset and the shared pins are not resampled.
`timescale 1ns/100ps
module hub_strap_top
  import hub_strap_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic upstream_power_detect_i,
  output logic attach_pullup_o,
  input wire logic power_polarity_strap_i,
  output logic [3:0] port_power_enable_o,
  input wire logic [1:0] green_led_high_ports_i,
  output logic [1:0] green_led_high_ports_o,
  output logic [1:0] green_led_high_ports_oe_o,
  input wire logic [1:0] green_led_low_ports_i,
  output logic [1:0] green_led_low_ports_o,
  output logic [1:0] green_led_low_ports_oe_o,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o
);
  // pin synchronisers: {polarity, gr4, gr3, gr2, gr1, vbus}
  logic [5:0] pin_sync;
  bit_sync #(.W(6)) u_sync (
    .clk_i(clk_i),
    .pin_i({power_polarity_strap_i, green_led_high_ports_i, green_led_low_ports_i,
            upstream_power_detect_i}),
    .sync_o(pin_sync)
  );
  logic vbus_s;
  assign vbus_s = pin_sync[0];

  // strap loader state
  loader_state_t ld_state_r;
  loader_state_t ld_state_nxt;
  logic pol_r;
  logic pol_nxt;
  logic [1:0] dis_code_r;
  logic [1:0] dis_code_nxt;
  logic [1:0] fix_code_r;
  logic [1:0] fix_code_nxt;
  logic done;
  assign done = (ld_state_r == LD_DONE);

  always_comb
  begin
    ld_state_nxt = ld_state_r;
    pol_nxt = pol_r;
    dis_code_nxt = dis_code_r;
    fix_code_nxt = fix_code_r;
    case (ld_state_r)
      LD_WAIT:
      begin
        // first edge after release; pins were undriven through reset
        ld_state_nxt = LD_DONE;
        pol_nxt = pin_sync[5]; // RULE11
        dis_code_nxt = pin_sync[4:3]; // RULE4
        fix_code_nxt = pin_sync[2:1]; // RULE7
      end
      LD_DONE:
      begin
        ld_state_nxt = LD_DONE; // RULE12
      end
      default:
      begin
        ld_state_nxt = LD_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ld_state_r <= LD_WAIT;
      pol_r <= 1'h1;
      dis_code_r <= 2'h0;
      fix_code_r <= 2'h0;
    end
    else
    begin
      ld_state_r <= ld_state_nxt;
      pol_r <= pol_nxt;
      dis_code_r <= dis_code_nxt;
      fix_code_r <= fix_code_nxt;
    end
  end

  // strap decode into per-port masks, index 3 is port 4
  logic [2:0] dis_ladder;
  logic [2:0] fix_ladder;
  strap_ladder u_dis (.code_i(dis_code_r), .mask_o(dis_ladder));
  strap_ladder u_fix (.code_i(fix_code_r), .mask_o(fix_ladder));
  logic [3:0] dis_mask;
  logic [3:0] fix_mask;
  assign dis_mask = {dis_ladder[0], dis_ladder[1], dis_ladder[2], 1'h0}; // RULE5
  assign fix_mask = {1'h0, fix_ladder[2], fix_ladder[1], fix_ladder[0]}; // RULE8

  // software registers
  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;
  logic [3:0] pwr_req_r;
  logic [3:0] pwr_req_nxt;
  logic [3:0] led_on_r;
  logic [3:0] led_on_nxt;
  logic ext_cfg;
  logic led_sup;
  assign ext_cfg = ctrl_r[CTRL_EXT_POS];
  assign led_sup = ctrl_r[CTRL_LEDSUP_POS];

  // pin output group
  logic attach_r;
  logic attach_nxt;
  logic [3:0] pwr_on_r;
  logic [3:0] pwr_on_nxt;
  logic [3:0] led_out_r;
  logic [3:0] led_out_nxt;
  logic [3:0] led_oe_r;
  logic [3:0] led_oe_nxt;
  logic [3:0] led_act_low;

  always_comb
  begin
    attach_nxt = vbus_s & ctrl_r[CTRL_ATTACH_POS] & done; // RULE1
    pwr_on_nxt = pwr_req_r & ~dis_mask & {4{done}};
    // RULE3 RULE6 RULE9
    led_act_low = ext_cfg ? 4'hF : {dis_code_r, fix_code_r};
    led_out_nxt = led_on_r ^ led_act_low;
    // pins stay inputs until the straps are held, so no resampling hazard
    led_oe_nxt = {4{done & (~ext_cfg | led_sup)}}; // RULE12
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      attach_r <= 1'h0;
      pwr_on_r <= 4'h0;
      led_out_r <= 4'h0;
      led_oe_r <= 4'h0;
    end
    else
    begin
      attach_r <= attach_nxt;
      pwr_on_r <= pwr_on_nxt;
      led_out_r <= led_out_nxt;
      led_oe_r <= led_oe_nxt;
    end
  end

  // the polarity must act through reset, so this path is combinational
  logic pol_eff;
  assign pol_eff = (nrst_i && done) ? pol_r : power_polarity_strap_i; // RULE10
  assign port_power_enable_o = ~(pwr_on_r ^ {4{pol_eff}}); // RULE2
  assign attach_pullup_o = attach_r;
  assign green_led_high_ports_o = led_out_r[3:2];
  assign green_led_low_ports_o = led_out_r[1:0];
  assign green_led_high_ports_oe_o = led_oe_r[3:2];
  assign green_led_low_ports_oe_o = led_oe_r[1:0];

  // axi4-lite slave
  logic aw_full_r;
  logic aw_full_nxt;
  logic [ADDR_W-1:0] awaddr_r;
  logic [ADDR_W-1:0] awaddr_nxt;
  logic w_full_r;
  logic w_full_nxt;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] wdata_nxt;
  logic [3:0] wstrb_r;
  logic [3:0] wstrb_nxt;
  logic awready_r;
  logic awready_nxt;
  logic wready_r;
  logic wready_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic arready_r;
  logic arready_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;
  logic [DATA_W-1:0] status_word;

  always_comb
  begin
    status_word = '0;
    status_word[STAT_VBUS_POS] = vbus_s;
    status_word[STAT_ATTACH_POS] = attach_r;
    status_word[STAT_POL_POS] = pol_r;
    status_word[STAT_DONE_POS] = done;
    status_word[STAT_DIS_LSB +: 4] = dis_mask;
    status_word[STAT_FIX_LSB +: 4] = fix_mask;
    status_word[STAT_DCODE_LSB +: 2] = dis_code_r;
    status_word[STAT_FCODE_LSB +: 2] = fix_code_r;
  end

  always_comb
  begin
    aw_full_nxt = aw_full_r;
    awaddr_nxt = awaddr_r;
    w_full_nxt = w_full_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    ctrl_nxt = ctrl_r;
    pwr_req_nxt = pwr_req_r;
    led_on_nxt = led_on_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (awready_r && s_axi_awvalid_i)
    begin
      aw_full_nxt = 1'h1;
      awaddr_nxt = s_axi_awaddr_i;
    end
    if (wready_r && s_axi_wvalid_i)
    begin
      w_full_nxt = 1'h1;
      wdata_nxt = s_axi_wdata_i;
      wstrb_nxt = s_axi_wstrb_i;
    end
    if (bvalid_r && s_axi_bready_i)
    begin
      bvalid_nxt = 1'h0;
    end
    if (aw_full_r && w_full_r && !bvalid_r)
    begin
      aw_full_nxt = 1'h0;
      w_full_nxt = 1'h0;
      bvalid_nxt = 1'h1;
      bresp_nxt = RESP_OKAY;
      case ({awaddr_r[3:2], 2'h0})
        REG_CTRL:
        begin
          if (wstrb_r[0])
          begin
            ctrl_nxt = wdata_r[CTRL_W-1:0];
          end
        end
        REG_PORT:
        begin
          if (wstrb_r[0])
          begin
            pwr_req_nxt = wdata_r[PORT_PWR_LSB +: 4];
          end
          if (wstrb_r[1])
          begin
            led_on_nxt = wdata_r[PORT_LED_LSB +: 4];
          end
        end
        REG_STATUS:
        begin
          bresp_nxt = RESP_OKAY;
        end
        default:
        begin
          bresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_r && s_axi_rready_i)
    begin
      rvalid_nxt = 1'h0;
    end
    if (arready_r && s_axi_arvalid_i)
    begin
      rvalid_nxt = 1'h1;
      rresp_nxt = RESP_OKAY;
      case ({s_axi_araddr_i[3:2], 2'h0})
        REG_CTRL:
        begin
          rdata_nxt = {{(DATA_W-CTRL_W){1'h0}}, ctrl_r};
        end
        REG_PORT:
        begin
          rdata_nxt = '0;
          rdata_nxt[PORT_PWR_LSB +: 4] = pwr_req_r;
          rdata_nxt[PORT_LED_LSB +: 4] = led_on_r;
        end
        REG_STATUS:
        begin
          rdata_nxt = status_word;
        end
        default:
        begin
          rdata_nxt = '0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    awready_nxt = ~aw_full_nxt;
    wready_nxt = ~w_full_nxt;
    arready_nxt = ~rvalid_nxt;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      aw_full_r <= 1'h0;
      awaddr_r <= 4'h0;
      w_full_r <= 1'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      awready_r <= 1'h0;
      wready_r <= 1'h0;
      bvalid_r <= 1'h0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'h0;
      rvalid_r <= 1'h0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
      ctrl_r <= CTRL_RESET;
      pwr_req_r <= PORT_PWR_RESET;
      led_on_r <= PORT_LED_RESET;
    end
    else
    begin
      aw_full_r <= aw_full_nxt;
      awaddr_r <= awaddr_nxt;
      w_full_r <= w_full_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      ctrl_r <= ctrl_nxt;
      pwr_req_r <= pwr_req_nxt;
      led_on_r <= led_on_nxt;
    end
  end

  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o = wready_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;

  // checks
  attach_follows_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE1
    (done && ctrl_r[CTRL_ATTACH_POS] && upstream_power_detect_i)[*4] |-> attach_pullup_o)
    else $error("attach pull-up not raised with upstream power present");
  power_disabled_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE2
    done && $past(done) && $past(dis_mask[3]) |-> port_power_enable_o[3] == ~pol_r)
    else $error("disabled port 4 power output not at inactive level");
  led_ext_low_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE3
    done && ext_cfg && led_sup && led_on_r == 4'hF |=> led_out_r == 4'h0 && led_oe_r == 4'hF)
    else $error("green leds not driven active low under external configuration");
  strap_capture_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE4
    $rose(done) |-> dis_code_r == $past(pin_sync[4:3]) && fix_code_r == $past(pin_sync[2:1]))
    else $error("straps not captured at reset release");
  disable_decode_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE5
    done |-> dis_mask == {|dis_code_r, dis_code_r[1], &dis_code_r, 1'h0})
    else $error("port disable strap decoded wrongly");
  high_led_pol_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE6
    done && !ext_cfg && led_on_r[3:2] == 2'h0 |=> green_led_high_ports_o == dis_code_r)
    else $error("port 4 or 3 green led off level wrong");
  fixed_decode_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE8
    done |-> fix_mask == {1'h0, &fix_code_r, fix_code_r[1], |fix_code_r})
    else $error("fixed device strap decoded wrongly");
  low_led_pol_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE9
    done && !ext_cfg && led_on_r[1:0] == 2'h3 |=> green_led_low_ports_o == ~fix_code_r)
    else $error("port 2 or 1 green led on level wrong");
  reset_power_off_a: assert property (@(posedge clk_i) // RULE10
    !nrst_i |-> port_power_enable_o == {4{~power_polarity_strap_i}})
    else $error("port power not inactive during reset");
  straps_held_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE12
    done && $past(done) |-> $stable(pol_r) && $stable(dis_code_r) && $stable(fix_code_r))
    else $error("latched strap changed after release");
endmodule

// *** verification/hub_board_model.sv ***
// board around the hub pins: strap resistors on the shared green led pins and the
// external port power switch
// assumes the switch polarity is wired to match the polarity strap
`timescale 1ns/100ps
module hub_board_model (
  input wire logic [1:0] strap_high_i,
  input wire logic [1:0] strap_low_i,
  input wire logic [1:0] led_high_i,
  input wire logic [1:0] led_high_oe_i,
  input wire logic [1:0] led_low_i,
  input wire logic [1:0] led_low_oe_i,
  input wire logic pol_i,
  input wire logic [3:0] power_en_i,
  output logic [1:0] pin_high_o,
  output logic [1:0] pin_low_o,
  output logic [3:0] powered_o
);
  // a released pin falls back to its strap resistor, never to the last driven level
  always_comb
  begin
    for (int b = 0; b < 2; b++)
    begin
      pin_high_o[b] = led_high_oe_i[b] ? led_high_i[b] : strap_high_i[b];
      pin_low_o[b] = led_low_oe_i[b] ? led_low_i[b] : strap_low_i[b];
    end
    powered_o = pol_i ? power_en_i : ~power_en_i;
  end
endmodule

// *** verification/hub_port_strap_and_led_pins_tb.sv ***
// self-checking bench for the hub strap, port power and green led pin block
// assumes the board model and an axi4-lite master driven from this module
`timescale 1ns/100ps
module hub_port_strap_and_led_pins_tb;
  import hub_strap_pkg::*;
  typedef struct packed {logic [1:0] dis; logic [1:0] fix; logic pol;} row_t;
  logic clk_i, nrst_i, vbus, pol, attach;
  logic [3:0] pwr, powered, wstrb;
  logic [1:0] hi_o, hi_oe, lo_o, lo_oe, hi_pin, lo_pin, st_hi, st_lo, bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, d;
  int n_fail, checked, cyc;
  // every strap code appears once and each polarity twice
  row_t rows [4] = '{'{2'h0, 2'h3, 1'b1}, '{2'h1, 2'h2, 1'b0}, '{2'h2, 2'h1, 1'b1},
    '{2'h3, 2'h0, 1'b0}};

  hub_strap_top dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .upstream_power_detect_i(vbus),
    .attach_pullup_o(attach), .power_polarity_strap_i(pol), .port_power_enable_o(pwr),
    .green_led_high_ports_i(hi_pin), .green_led_high_ports_o(hi_o),
    .green_led_high_ports_oe_o(hi_oe), .green_led_low_ports_i(lo_pin),
    .green_led_low_ports_o(lo_o), .green_led_low_ports_oe_o(lo_oe),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp));

  hub_board_model board_u (.strap_high_i(st_hi), .strap_low_i(st_lo), .led_high_i(hi_o),
    .led_high_oe_i(hi_oe), .led_low_i(lo_o), .led_low_oe_i(lo_oe), .pol_i(pol),
    .power_en_i(pwr), .pin_high_o(hi_pin), .pin_low_o(lo_pin), .powered_o(powered));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  function automatic logic [3:0] dmask(input logic [1:0] c);
    return (c == 2'h0) ? 4'h0 : (c == 2'h1) ? 4'h8 : (c == 2'h2) ? 4'hC : 4'hE;
  endfunction

  function automatic logic [3:0] fmask(input logic [1:0] c);
    return (c == 2'h0) ? 4'h0 : (c == 2'h1) ? 4'h1 : (c == 2'h2) ? 4'h3 : 4'h7;
  endfunction

  function automatic logic [31:0] exp_stat(input row_t w);
    return {16'h0000, w.fix, w.dis, fmask(w.fix), dmask(w.dis), 1'b1, w.pol, 2'h3};
  endfunction

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk_v(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // generous ceiling: the whole sequence needs well under 2000 cycles
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      end_sim();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ap, wp;
    ap = 1'b1;
    wp = 1'b1;
    @(posedge clk_i);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    wstrb <= 4'hF;
    bready <= 1'b1;
    while (ap || wp)
    begin
      @(posedge clk_i);
      if (ap && awready === 1'b1)
      begin
        ap = 1'b0;
        awvalid <= 1'b0;
      end
      if (wp && wready === 1'b1)
      begin
        wp = 1'b0;
        wvalid <= 1'b0;
      end
    end
    @(posedge clk_i);
    while (bvalid !== 1'b1)
      @(posedge clk_i);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk_i);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    @(posedge clk_i);
    while (arready !== 1'b1)
      @(posedge clk_i);
    arvalid <= 1'b0;
    @(posedge clk_i);
    while (rvalid !== 1'b1)
      @(posedge clk_i);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // straps stay put for several edges on both sides of the release
  task automatic strap_reset(input row_t w);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    pol <= w.pol;
    st_hi <= w.dis;
    st_lo <= w.fix;
    repeat (8) @(posedge clk_i);
    chk_v("power_in_reset", {4{~w.pol}}, pwr);
    pol <= ~w.pol;
    @(negedge clk_i);
    chk_v("power_in_reset_flip", {4{w.pol}}, pwr);
    @(posedge clk_i);
    pol <= w.pol;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask

  initial
  begin
    nrst_i = 1'b0;
    vbus = 1'b1;
    pol = 1'b1;
    st_hi = 2'h0;
    st_lo = 2'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b0;
    rready = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h0;
    foreach (rows[i])
    begin
      strap_reset(rows[i]);
      rd(REG_CTRL, d, r);
      chk_v("ctrl_reset", {29'h0, CTRL_RESET}, d);
      rd(REG_STATUS, d, r);
      chk_v("status", exp_stat(rows[i]), d);
      wr(REG_PORT, 32'h0000_0F0F, r);
      repeat (2) @(posedge clk_i);
      chk_v("power_on", dmask(rows[i].dis) ^ {4{rows[i].pol}}, pwr);
      chk_v("switch_on", dmask(rows[i].dis) ^ 4'hF, powered);
      chk_v("led_oe", 4'hF, {hi_oe, lo_oe});
      chk_v("led_high_on", rows[i].dis ^ 2'h3, hi_o);
      chk_v("led_low_on", rows[i].fix ^ 2'h3, lo_o);
      st_hi <= rows[i].dis ^ 2'h3;
      st_lo <= rows[i].fix ^ 2'h3;
      wr(REG_PORT, 32'h0000_0000, r);
      repeat (2) @(posedge clk_i);
      chk_v("power_off", {4{~rows[i].pol}}, pwr);
      chk_v("led_high_off", rows[i].dis, hi_o);
      chk_v("led_low_off", rows[i].fix, lo_o);
      rd(REG_STATUS, d, r);
      chk_v("status_held", exp_stat(rows[i]), d);
    end
    // external configuration with led support: every green led active low
    wr(REG_CTRL, 32'h0000_0007, r);
    wr(REG_PORT, 32'h0000_0F00, r);
    repeat (2) @(posedge clk_i);
    chk_v("ext_led_on", 4'h0, {hi_o, lo_o});
    chk_v("ext_power_idle", 4'hF, pwr);
    wr(REG_PORT, 32'h0000_0000, r);
    repeat (2) @(posedge clk_i);
    chk_v("ext_led_off", 4'hF, {hi_o, lo_o});
    wr(REG_CTRL, 32'h0000_0003, r);
    repeat (2) @(posedge clk_i);
    chk_v("ext_led_released", 4'h0, {hi_oe, lo_oe});
    vbus <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk_v("attach_low", 1'b0, attach);
    vbus <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk_v("attach_high", 1'b1, attach);
    wr(4'hC, 32'hFFFF_FFFF, r);
    chk_v("bresp_unmapped", RESP_SLVERR, r);
    rd(4'hC, d, r);
    chk_v("rresp_unmapped", RESP_SLVERR, r);
    chk_v("rdata_unmapped", 32'h0, d);
    wr(REG_STATUS, 32'h0000_0000, r);
    chk_v("bresp_status", RESP_OKAY, r);
    rd(REG_STATUS, d, r);
    chk_v("status_ro", exp_stat(rows[3]), d);
    end_sim();
  end
endmodule
